// ==== verilog/rsu_shift_unit.sv ====
// register shift unit: single or paired register shift driven by a down-counter
//
// Contract
// - shift one register, or it with its successor as one 64-bit operand.
// - logical shift discards bits leaving an end; vacated positions get zeros.
// - circular shift feeds bits leaving one end into the opposite end.
// - arithmetic right replicates sign bit; arithmetic left equals logical left.
// - type bits 21..23: 00X logical, 01X circular, 10X arithmetic.
// - bit 23 one selects single register; zero selects register pair.
// - type bits come from the instruction word, untouched by indexing.
// - address bits 25..31 are a signed count; positive left, negative right.
// - positions moved equal the count magnitude, zero through 64.
// - after any right shift the two high condition bits are zero.
// - after left shift parity bit shows odd number of ones shifted out.
// - after left shift overflow bit set if sign position overflowed.
// - left: count into counter, register into upper, zero or partner lower.
// - left shift moves one bit per clock, counter decrements by one.
// - left: upper msb discarded, or to upper/lower bit 31 when circular.
// - right: inverted count bits load counter, odd flag from count lsb.
// - odd right count shifts one first, then twos; counter drops by two.
// - right: lsb discarded or recirculated; arithmetic replicates upper sign.
// - shifting stops at counter zero; result written back to origin.
// - setup sets the direction flag when the count sign is one.
// - setup clears parity, overflow and lower word; right keeps codes clear.
// - zero left count skips iterations and completes at once.
// - iteration phase persists while counter nonzero or I/O hold active.
`timescale 1ns/1ps

module rsu_shift_unit (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // request from the phase sequencer
  input  wire logic                        start,
  input  wire logic [rsu_pkg::WORD_W-1:0]  type_word,
  input  wire logic [rsu_pkg::WORD_W-1:0]  eff_addr,
  input  wire logic                        io_hold,
  // operands from the register file
  input  wire logic [rsu_pkg::WORD_W-1:0]  reg_r,
  input  wire logic [rsu_pkg::WORD_W-1:0]  reg_r1,
  // write-back and completion
  output logic                             busy,
  output logic                             done,
  output logic                             wb_en,
  output logic                             wb_pair,
  output logic [rsu_pkg::WORD_W-1:0]       wb_hi,
  output logic [rsu_pkg::WORD_W-1:0]       wb_lo,
  // condition codes (high two bits only)
  output logic                             cc_wr,
  output logic                             ones_parity_code,
  output logic                             overflow_code
);

  // working state
  rsu_pkg::rsu_state_t             state;
  rsu_pkg::rsu_kind_t              kind;
  logic                            single;
  logic                            direction_flag;
  logic                            odd_count_flag;
  logic [rsu_pkg::CNT_W-1:0]       step_counter;
  logic [rsu_pkg::WORD_W-1:0]      a_word;
  logic [rsu_pkg::WORD_W-1:0]      b_word;
  logic [rsu_pkg::WORD_W-1:0]      pair_partner_reg;
  logic                            count_zero;
  logic                            step_go;
  logic [2*rsu_pkg::WORD_W-1:0]    right1;
  logic [2*rsu_pkg::WORD_W-1:0]    right2;
  logic [2*rsu_pkg::WORD_W-1:0]    left1;

  // decode the type bits; 11X is not defined and falls back to logical
  function automatic rsu_pkg::rsu_kind_t decode_kind(input logic [rsu_pkg::WORD_W-1:0] w);
    if (w[rsu_pkg::TYPE_ARITH_POS] && !w[rsu_pkg::TYPE_CIRC_POS]) begin
      decode_kind = rsu_pkg::KIND_ARITH;
    end else if (!w[rsu_pkg::TYPE_ARITH_POS] && w[rsu_pkg::TYPE_CIRC_POS]) begin
      decode_kind = rsu_pkg::KIND_CIRCULAR;
    end else begin
      decode_kind = rsu_pkg::KIND_LOGICAL;
    end
  endfunction : decode_kind

  // one right step of the combined words; used twice for a double step
  function automatic logic [2*rsu_pkg::WORD_W-1:0] step_right(
    input logic [2*rsu_pkg::WORD_W-1:0] ab,
    input rsu_pkg::rsu_kind_t           k,
    input logic                         sgl
  );
    logic [rsu_pkg::WORD_W-1:0] a;
    logic [rsu_pkg::WORD_W-1:0] b;
    logic                       fill;
    a = ab[2*rsu_pkg::WORD_W-1:rsu_pkg::WORD_W];
    b = ab[rsu_pkg::WORD_W-1:0];
    case (k)
      rsu_pkg::KIND_CIRCULAR: fill = sgl ? a[0] : b[0];
      rsu_pkg::KIND_ARITH:    fill = a[rsu_pkg::WORD_W-1];
      default:                fill = 1'b0;
    endcase
    if (sgl) begin
      step_right = {fill, a[rsu_pkg::WORD_W-1:1], b};
    end else begin
      step_right = {fill, a[rsu_pkg::WORD_W-1:1], a[0], b[rsu_pkg::WORD_W-1:1]};
    end
  endfunction : step_right

  // next operand values for each kind of step
  always_comb begin
    right1 = step_right({a_word, b_word}, kind, single);
    right2 = step_right(right1, kind, single);
    // left: upper msb leaves; lower msb moves up; bit 31 ends take the circular feed
    left1 = {a_word[rsu_pkg::WORD_W-2:0], b_word[rsu_pkg::WORD_W-1],
             b_word[rsu_pkg::WORD_W-2:0], 1'b0};
    if (kind == rsu_pkg::KIND_CIRCULAR) begin
      if (single) begin
        left1[rsu_pkg::WORD_W] = a_word[rsu_pkg::WORD_W-1];
      end else begin
        left1[0] = a_word[rsu_pkg::WORD_W-1];
      end
    end
  end

  // counter state and the hold from i/o service
  assign count_zero = (step_counter == rsu_pkg::CNT_RESET);
  assign step_go    = (state == rsu_pkg::ST_SHIFT) && !io_hold;

  // phase sequencing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= rsu_pkg::ST_IDLE;
    end else begin
      case (state)
        rsu_pkg::ST_IDLE: begin
          if (start) begin
            state <= rsu_pkg::ST_LOAD;
          end
        end
        rsu_pkg::ST_LOAD: begin
          if (!direction_flag && count_zero) begin
            state <= rsu_pkg::ST_DONE;
          end else begin
            state <= rsu_pkg::ST_SHIFT;
          end
        end
        rsu_pkg::ST_SHIFT: begin
          if (step_go && count_zero) begin
            state <= rsu_pkg::ST_DONE;
          end
        end
        rsu_pkg::ST_DONE: begin
          state <= rsu_pkg::ST_IDLE;
        end
        default: begin
          state <= rsu_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // instruction decode latched at setup; caller guarantees an even pair index
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kind           <= rsu_pkg::KIND_LOGICAL;
      single         <= 1'b1;
      direction_flag <= 1'b0;
      odd_count_flag <= 1'b0;
    end else if (state == rsu_pkg::ST_IDLE && start) begin
      kind           <= decode_kind(type_word);
      single         <= type_word[rsu_pkg::TYPE_SINGLE_POS];
      direction_flag <= eff_addr[rsu_pkg::COUNT_SIGN_POS];
      odd_count_flag <= eff_addr[rsu_pkg::COUNT_SIGN_POS] &&
                        eff_addr[rsu_pkg::COUNT_ODD_POS];
    end else if (step_go && direction_flag) begin
      odd_count_flag <= 1'b0;
    end
  end

  // iteration counter: left counts by one, right by two from the inverted load
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_counter <= rsu_pkg::CNT_RESET;
    end else if (state == rsu_pkg::ST_IDLE && start) begin
      if (eff_addr[rsu_pkg::COUNT_SIGN_POS]) begin
        step_counter <= {1'b0, ~eff_addr[rsu_pkg::COUNT_MAG_HI:rsu_pkg::COUNT_MAG_LO], 1'b0};
      end else begin
        step_counter <= {1'b0, eff_addr[rsu_pkg::COUNT_MAG_HI:0]};
      end
    end else if (state == rsu_pkg::ST_LOAD && !direction_flag) begin
      step_counter <= step_counter - rsu_pkg::LEFT_DEC;
    end else if (step_go) begin
      if (direction_flag) begin
        step_counter <= step_counter - rsu_pkg::RIGHT_DEC;
      end else begin
        step_counter <= step_counter - rsu_pkg::LEFT_DEC;
      end
    end
  end

  // operand words; lower word cleared at setup so a single shift sees zeros
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_word           <= rsu_pkg::WORD_RESET;
      b_word           <= rsu_pkg::WORD_RESET;
      pair_partner_reg <= rsu_pkg::WORD_RESET;
    end else if (state == rsu_pkg::ST_IDLE && start) begin
      a_word           <= reg_r;
      b_word           <= rsu_pkg::WORD_RESET;
      pair_partner_reg <= reg_r1;
    end else if (state == rsu_pkg::ST_LOAD) begin
      if (!single) begin
        b_word <= pair_partner_reg;
      end
    end else if (step_go) begin
      if (!direction_flag) begin
        {a_word, b_word} <= left1;
      end else if (odd_count_flag) begin
        {a_word, b_word} <= right1;
      end else begin
        {a_word, b_word} <= right2;
      end
    end
  end

  // condition codes: only left steps touch them, so right leaves them clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ones_parity_code <= 1'b0;
      overflow_code    <= 1'b0;
    end else if (state == rsu_pkg::ST_IDLE && start) begin
      ones_parity_code <= 1'b0;
      overflow_code    <= 1'b0;
    end else if (step_go && !direction_flag) begin
      ones_parity_code <= ones_parity_code ^ a_word[rsu_pkg::WORD_W-1];
      if (a_word[rsu_pkg::WORD_W-1] != a_word[rsu_pkg::WORD_W-2]) begin
        overflow_code <= 1'b1;
      end
    end
  end

  // write-back and completion leave together, one cycle each
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done    <= 1'b0;
      wb_en   <= 1'b0;
      cc_wr   <= 1'b0;
      wb_pair <= 1'b0;
      wb_hi   <= rsu_pkg::WORD_RESET;
      wb_lo   <= rsu_pkg::WORD_RESET;
    end else begin
      done    <= (state == rsu_pkg::ST_DONE);
      wb_en   <= (state == rsu_pkg::ST_DONE);
      cc_wr   <= (state == rsu_pkg::ST_DONE);
      if (state == rsu_pkg::ST_DONE) begin
        wb_pair <= !single;
        wb_hi   <= a_word;
        wb_lo   <= b_word;
      end
    end
  end

  // busy from request to the write-back cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else if (state == rsu_pkg::ST_IDLE && start) begin
      busy <= 1'b1;
    end else if (state == rsu_pkg::ST_DONE) begin
      busy <= 1'b0;
    end
  end

  // checks on the block's own behaviour
  AST_DONE_WITH_WB: assert property (@(posedge clk) disable iff (!nrst)
    done |-> wb_en && cc_wr)
    else $error("completion without write-back");

  AST_RIGHT_CC_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    (done && direction_flag) |-> (!ones_parity_code && !overflow_code))
    else $error("right shift left high condition bits set");

  AST_ZERO_LEFT_SKIP: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_LOAD && !direction_flag && count_zero) |=> ##1 done)
    else $error("zero left count did not complete at once");

  AST_SETUP_FLAGS: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_IDLE && start) |=>
      (direction_flag == $past(eff_addr[rsu_pkg::COUNT_SIGN_POS])) && !ones_parity_code && b_word == 32'h00000000)
    else $error("setup flags wrong");

  AST_LEFT_DEC1: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && !direction_flag && !count_zero) |=> step_counter == $past(step_counter) - 7'h01)
    else $error("left step did not decrement by one");

  AST_RIGHT_DEC2: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && direction_flag && !count_zero) |=>
      (step_counter == $past(step_counter) - 7'h02) && !odd_count_flag)
    else $error("right step did not decrement by two");

  AST_IO_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_SHIFT && io_hold) |=> $stable(a_word) && $stable(step_counter) && state == rsu_pkg::ST_SHIFT)
    else $error("shifting moved during i/o hold");

  AST_ARITH_SIGN: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && direction_flag && kind == rsu_pkg::KIND_ARITH) |=> a_word[31] == $past(a_word[31]))
    else $error("arithmetic right lost sign");

  AST_SINGLE_LOWER_ZERO: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_LOAD && single) |=> b_word == 32'h00000000)
    else $error("single shift lower word not zero");

  // handshake and stepping checks
  AST_BUSY_AFTER_START: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_IDLE && start) |=> busy)
    else $error("busy did not rise after request");

  AST_DONE_ONE_CYCLE: assert property (@(posedge clk) disable iff (!nrst)
    done |=> !done)
    else $error("completion longer than one cycle");

  AST_BUSY_LOW_AT_DONE: assert property (@(posedge clk) disable iff (!nrst)
    done |-> !busy)
    else $error("busy still high at completion");

  AST_LEFT_ONE_BIT: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && !direction_flag && kind != rsu_pkg::KIND_CIRCULAR) |=>
      a_word == {$past(a_word[rsu_pkg::WORD_W-2:0]), $past(b_word[rsu_pkg::WORD_W-1])})
    else $error("left step did not move one bit");

  AST_LEFT_CIRC_SINGLE: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && !direction_flag && kind == rsu_pkg::KIND_CIRCULAR && single) |=>
      a_word == {$past(a_word[rsu_pkg::WORD_W-2:0]), $past(a_word[rsu_pkg::WORD_W-1])})
    else $error("single circular left lost its msb");

  AST_LEFT_CIRC_PAIR: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && !direction_flag && kind == rsu_pkg::KIND_CIRCULAR && !single) |=>
      b_word[0] == $past(a_word[rsu_pkg::WORD_W-1]))
    else $error("pair circular left lost its msb");

  AST_RIGHT_ZERO_FILL: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && direction_flag && kind == rsu_pkg::KIND_LOGICAL) |=> !a_word[rsu_pkg::WORD_W-1])
    else $error("logical right did not fill zeros");

  AST_SETUP_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_IDLE && start) |=> a_word == $past(reg_r))
    else $error("upper word not loaded from register");

  AST_PAIR_LOWER_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_LOAD && !single) |=> b_word == $past(pair_partner_reg))
    else $error("lower word not loaded from successor");

  AST_RIGHT_KEEPS_CC: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_SHIFT && direction_flag) |-> (!ones_parity_code && !overflow_code))
    else $error("condition bits set during right shift");

  AST_ODD_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_IDLE && start) |=>
      odd_count_flag == ($past(eff_addr[rsu_pkg::COUNT_SIGN_POS]) && $past(eff_addr[rsu_pkg::COUNT_ODD_POS])))
    else $error("odd count flag loaded wrong");

  AST_STEP_STOPS: assert property (@(posedge clk) disable iff (!nrst)
    (step_go && count_zero) |=> state == rsu_pkg::ST_DONE)
    else $error("shifting did not stop at zero count");

  AST_WB_PAIR: assert property (@(posedge clk) disable iff (!nrst)
    wb_en |-> wb_pair == !single)
    else $error("write-back width differs from request");

  AST_HOLD_KEEPS_CC: assert property (@(posedge clk) disable iff (!nrst)
    (state == rsu_pkg::ST_SHIFT && io_hold) |=> $stable(ones_parity_code) && $stable(overflow_code))
    else $error("condition bits moved during i/o hold");

  // main scenarios
  COV_LEFT_DONE: cover property (@(posedge clk) disable iff (!nrst)
    done && !direction_flag && ones_parity_code);
  COV_RIGHT_ODD: cover property (@(posedge clk) disable iff (!nrst)
    step_go && direction_flag && odd_count_flag && !count_zero);
  COV_ZERO_SKIP: cover property (@(posedge clk) disable iff (!nrst)
    state == rsu_pkg::ST_LOAD && !direction_flag && count_zero);
  COV_PAIR_CIRC: cover property (@(posedge clk) disable iff (!nrst)
    done && wb_pair && kind == rsu_pkg::KIND_CIRCULAR);
  COV_IO_HOLD: cover property (@(posedge clk) disable iff (!nrst)
    state == rsu_pkg::ST_SHIFT && io_hold && !count_zero);

endmodule : rsu_shift_unit

// ==== verilog/rsu_pkg.sv ====
// shared constants and types for the register shift unit
package rsu_pkg;

  // operand and counter widths
  localparam int WORD_W = 32;
  localparam int CNT_W  = 7;

  // type-select bits, held in the instruction or indirect word (msb-first bits 21..23)
  localparam int TYPE_ARITH_POS  = 10;
  localparam int TYPE_CIRC_POS   = 9;
  localparam int TYPE_SINGLE_POS = 8;

  // signed count field of the effective address (msb-first bits 25..31)
  localparam int COUNT_SIGN_POS = 6;
  localparam int COUNT_MAG_HI   = 5;
  localparam int COUNT_MAG_LO   = 1;
  localparam int COUNT_ODD_POS  = 0;

  // values after reset
  localparam logic [CNT_W-1:0]  CNT_RESET  = 7'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h00000000;

  // counter step sizes per clock
  localparam logic [CNT_W-1:0] LEFT_DEC  = 7'h01;
  localparam logic [CNT_W-1:0] RIGHT_DEC = 7'h02;

  // shift kinds after decode
  typedef enum logic [1:0] {
    KIND_LOGICAL,
    KIND_CIRCULAR,
    KIND_ARITH
  } rsu_kind_t;

  // execution phases
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT,
    ST_DONE
  } rsu_state_t;

endpackage : rsu_pkg

// ==== bench/rsu_regfile_model.sv ====
// register file and sequencer stand-in facing the shift unit
`timescale 1ns/1ps

module rsu_regfile_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // bench side
  input  wire logic [3:0]  sel,
  input  wire logic        ld_en,
  input  wire logic [31:0] ld_hi,
  input  wire logic [31:0] ld_lo,
  // shift unit side
  input  wire logic        start,
  input  wire logic        busy,
  input  wire logic        wb_en,
  input  wire logic        wb_pair,
  input  wire logic [31:0] wb_hi,
  input  wire logic [31:0] wb_lo,
  output logic      [31:0] reg_r,
  output logic      [31:0] reg_r1
);
  logic [31:0] rf [16];
  logic [3:0]  cur;

  // forward a write-back that lands on the edge a new operand is sampled
  function automatic logic [31:0] rd(input logic [3:0] i);
    if (wb_en && i == cur) return wb_hi;
    if (wb_en && wb_pair && i == cur + 4'h1) return wb_lo;
    return rf[i];
  endfunction : rd

  // successor register is always the next index
  always_comb begin
    reg_r = rd(sel);
    reg_r1 = rd(sel + 4'h1);
  end

  // destination held from the accepted request until write-back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur <= 4'h0;
    end else if (start && !busy) begin
      cur <= sel;
    end
  end

  // bench loads never share an edge with a write-back
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) rf[i] <= 32'h0;
    end else if (ld_en) begin
      rf[sel] <= ld_hi;
      rf[sel + 4'h1] <= ld_lo;
    end else if (wb_en) begin
      rf[cur] <= wb_hi;
      if (wb_pair) rf[cur + 4'h1] <= wb_lo;
    end
  end
endmodule : rsu_regfile_model

// ==== bench/tb_rsu_shift_unit.sv ====
// self-checking bench for the register shift unit
`timescale 1ns/1ps

module tb_rsu_shift_unit;
  typedef struct {
    logic [31:0] hi;
    logic [31:0] lo;
    logic        pair;
    logic        par;
    logic        ov;
    int          lat;
  } rsu_exp_t;

  logic        clk = 1'b0, nrst = 1'b0, start = 1'b0, io_hold = 1'b0, ld_en = 1'b0, hold_en = 1'b0;
  logic [31:0] type_word = 32'h0, eff_addr = 32'h0, ld_hi = 32'h0, ld_lo = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] reg_r, reg_r1, wb_hi, wb_lo, mirror [16];
  logic        busy, done, wb_en, wb_pair, cc_wr, ones_parity_code, overflow_code;
  logic [6:0]  counts [12] = '{7'h00, 7'h01, 7'h02, 7'h1F, 7'h20, 7'h21, 7'h3F, 7'h7F, 7'h7E, 7'h79, 7'h41, 7'h40};
  rsu_exp_t    q [$];
  int          num_errors = 0, cmp_count = 0, cyc = 0;

  always #2.5 clk = ~clk;

  rsu_shift_unit i_dut (.clk(clk), .nrst(nrst), .start(start), .type_word(type_word), .eff_addr(eff_addr),
    .io_hold(io_hold), .reg_r(reg_r), .reg_r1(reg_r1), .busy(busy), .done(done), .wb_en(wb_en),
    .wb_pair(wb_pair), .wb_hi(wb_hi), .wb_lo(wb_lo), .cc_wr(cc_wr), .ones_parity_code(ones_parity_code),
    .overflow_code(overflow_code));

  rsu_regfile_model i_rf (.clk(clk), .nrst(nrst), .sel(sel), .ld_en(ld_en), .ld_hi(ld_hi), .ld_lo(ld_lo),
    .start(start), .busy(busy), .wb_en(wb_en), .wb_pair(wb_pair), .wb_hi(wb_hi), .wb_lo(wb_lo),
    .reg_r(reg_r), .reg_r1(reg_r1));

  task automatic err(input string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : err

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) err(msg);
  endtask : chk

  task automatic end_of_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // reference result, one bit per step so the two-bit right path is cross-checked
  function automatic rsu_exp_t model(input logic [31:0] tw, input logic [31:0] ea, input logic [31:0] r,
                                     input logic [31:0] r1);
    rsu_exp_t    e;
    logic [63:0] v;
    logic        ar, ci, sg, b;
    int          m;
    ar = tw[rsu_pkg::TYPE_ARITH_POS] & ~tw[rsu_pkg::TYPE_CIRC_POS];
    ci = tw[rsu_pkg::TYPE_CIRC_POS] & ~tw[rsu_pkg::TYPE_ARITH_POS];
    sg = tw[rsu_pkg::TYPE_SINGLE_POS];
    v = {r, sg ? 32'h0 : r1};
    e.par = 1'b0;
    e.ov = 1'b0;
    if (!ea[rsu_pkg::COUNT_SIGN_POS]) begin
      m = int'(ea[5:0]);
      e.lat = m;
      for (int i = 0; i < m; i++) begin
        e.par ^= v[63];
        e.ov |= v[63] ^ v[62];
        b = v[63];
        v = v << 1;
        if (ci) v[sg ? 32 : 0] = b;
      end
    end else begin
      m = 128 - int'(ea[6:0]);
      e.lat = (m + 1) / 2;
      for (int i = 0; i < m; i++) begin
        b = sg ? v[32] : v[0];
        if (sg) v[63:32] = {ci ? b : ar & v[63], v[63:33]};
        else v = {ci ? b : ar & v[63], v[63:1]};
      end
    end
    e.hi = v[63:32];
    e.lo = v[31:0];
    e.pair = ~sg;
    return e;
  endfunction : model

  // fresh operands into the register pair and the mirror
  task automatic load(input logic [3:0] idx);
    logic [31:0] h, l;
    h = $urandom();
    l = $urandom();
    @(posedge clk);
    sel <= idx;
    ld_en <= 1'b1;
    ld_hi <= h;
    ld_lo <= l;
    mirror[idx] = h;
    mirror[idx + 4'h1] = l;
    @(posedge clk);
    ld_en <= 1'b0;
  endtask : load

  // one shift; without hold, returns on the edge that opens its completion cycle, so requests run back to back; under hold, one edge later
  task automatic run(input logic [3:0] idx, input logic [31:0] tw, input logic [31:0] ea);
    rsu_exp_t e;
    int       n;
    e = model(tw, ea, mirror[idx], mirror[idx + 4'h1]);
    n = e.lat;
    mirror[idx] = e.hi;
    if (e.pair) mirror[idx + 4'h1] = e.lo;
    e.lat = hold_en ? -1 : cyc + 4 + n;
    q.push_back(e);
    sel <= idx;
    type_word <= tw;
    eff_addr <= ea;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    if (hold_en) begin
      for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clk);
    end else if (n >= 2) begin
      @(posedge clk);
      start <= 1'b1; // a request while busy must be ignored
      eff_addr <= $urandom();
      @(posedge clk);
      start <= 1'b0;
      repeat (n) @(posedge clk);
    end else begin
      repeat (n + 2) @(posedge clk);
    end
  endtask : run

  // cycle count, watchdog and random freezing of iterations
  always @(posedge clk) begin
    cyc <= cyc + 1;
    io_hold <= hold_en && ($urandom_range(1, 0) == 1);
    if (cyc == 40000) begin
      err("run did not finish");
      end_of_test();
    end
  end

  // each completion against the oldest prediction
  always @(posedge clk) begin
    rsu_exp_t e;
    if (nrst && wb_en !== done) err("write-back apart from completion");
    if (nrst && done === 1'b1) begin
      if (q.size() == 0) begin
        err("completion without request");
      end else begin
        e = q.pop_front();
        chk(wb_hi, e.hi, "upper word");
        chk(wb_lo, e.lo, "lower word");
        chk({31'h0, busy}, 32'h0, "busy at completion");
        chk({wb_pair, cc_wr, ones_parity_code, overflow_code}, {e.pair, 1'b1, e.par, e.ov}, "codes");
        if (e.lat >= 0) chk(cyc, e.lat, "latency");
      end
    end
  end

  initial begin
    logic [3:0]  idx;
    logic [31:0] tw, ea;
    void'($urandom(32'h77F3));
    foreach (mirror[i]) mirror[i] = 32'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // every type code, both widths, boundary counts; pairs on even registers
    for (int k = 0; k < 8; k++) begin
      foreach (counts[j]) begin
        idx = {3'($urandom()), 1'b0};
        tw = $urandom();
        tw[rsu_pkg::TYPE_ARITH_POS -: 3] = 3'(k);
        ea = $urandom();
        ea[6:0] = counts[j];
        load(idx);
        run(idx, tw, ea);
      end
    end
    // random traffic, chained results, then iterations frozen at random
    for (int i = 0; i < 300; i++) begin
      if (i == 250) begin
        hold_en <= 1'b1;
        @(posedge clk);
      end
      tw = $urandom();
      idx = 4'($urandom());
      if (!tw[rsu_pkg::TYPE_SINGLE_POS]) idx[0] = 1'b0;
      if (i % 4 != 0) load(idx);
      run(idx, tw, $urandom());
    end
    repeat (6) @(posedge clk);
    if (q.size() != 0) err("request never completed");
    end_of_test();
  end
endmodule : tb_rsu_shift_unit
